// ### inc/asc_pkg.sv
`default_nettype none
package asc_pkg;

  // ----------------------------------------------------------------
  // Register word indices (byte address is four times the index).
  // ----------------------------------------------------------------
  localparam logic [7:0] AUX_IDX   = 8'hA2;
  localparam logic [7:0] EDGE_IDX  = 8'hA3;
  localparam logic [7:0] LATCH_IDX = 8'h90;

  // ----------------------------------------------------------------
  // Reset values and fixed data patterns.
  // ----------------------------------------------------------------
  localparam logic [7:0] AUX_RESET_VAL  = 8'h00;
  localparam logic [7:0] EDGE_RESET_VAL = 8'h00;
  localparam logic [7:0] PORT_ALL_HIGH  = 8'hFF;
  localparam logic [7:0] PORT_ALL_LOW   = 8'h00;
  localparam logic [7:0] READ_ZERO      = 8'h00;
  localparam logic [1:0] PIN_RELEASED   = 2'h3;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SWRST_PULSE_NS = 100;
  localparam int SWRST_CYCLES   = (SWRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SQUARE_HALF    = 2048;
  localparam int CLOCK_OUTPUT_PIN_HALF    = 2;
  localparam int EDGE_PINS      = 3;

  // ----------------------------------------------------------------
  // Register layouts.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic edgeDetectFlag;
    logic brownoutDisable;
    logic brownoutIrqSelect;
    logic lowPowerBrownout;
    logic softwareReset;
    logic converterEnable;
    logic squareWaveEnable;
    logic reserved;
  } asc_aux_t;

  typedef struct packed {
    logic [1:0] edgeFilterSelect;
    logic       edge2Polarity;
    logic       edge2Enable;
    logic       edge1Polarity;
    logic       edge1Enable;
    logic       edge0Polarity;
    logic       edge0Enable;
  } asc_edge_t;

  // Port 1 pin drive as one bundle.
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] oeN;
  } asc_pins_t;

  typedef enum logic [1:0] {
    RS_POR  = 2'b00,
    RS_RUN  = 2'b01,
    RS_SOFT = 2'b10
  } asc_rst_state_t;

endpackage
`default_nettype wire

// ### logic/asc_sync3.sv
`timescale 1ns/100ps
`default_nettype none
module asc_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,     // System clock.
  input  wire logic             rst_n,    // Synchronous reset, active low.
  input  wire logic [WIDTH-1:0] asyncIn,  // Level from outside the domain.
  output logic      [WIDTH-1:0] syncOut   // Accepted level.
);

  logic [WIDTH-1:0] s1Reg, s2Reg, s3Reg, outReg;
  logic [WIDTH-1:0] outNext;

  // A bit changes only where the second and third stage agree.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      outNext[i] = (s2Reg[i] == s3Reg[i]) ? s3Reg[i] : outReg[i];
    end
  end

  // The first stage feeds the second stage only.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1Reg  <= '0;
      s2Reg  <= '0;
      s3Reg  <= '0;
      outReg <= '0;
    end else begin
      s1Reg  <= asyncIn;
      s2Reg  <= s1Reg;
      s3Reg  <= s2Reg;
      outReg <= outNext;
    end
  end

  assign syncOut = outReg;

endmodule
`default_nettype wire

// ### logic/asc_edge_det.sv
`timescale 1ns/100ps
`default_nettype none
module asc_edge_det #(
  parameter int PINS = 3
) (
  input  wire logic            mclk,      // System clock.
  input  wire logic            clear,     // Synchronous clear, active high.
  input  wire logic [PINS-1:0] level,     // Synchronised pin levels.
  input  wire logic [PINS-1:0] enable,    // Per-pin detection enable.
  input  wire logic [PINS-1:0] rising,    // 1 rising edge, 0 falling edge.
  output logic                 edgeHit    // One-cycle pulse on a wanted edge.
);

  logic [PINS-1:0] prevReg, prevNext;
  logic            hitReg,  hitNext;

  // Compare each level with its previous value and keep only wanted edges.
  always_comb begin
    prevNext = level;
    hitNext  = 1'b0;
    for (int i = 0; i < PINS; i++) begin
      if (enable[i] && (level[i] != prevReg[i]) && (level[i] == rising[i])) begin
        hitNext = 1'b1;
      end
    end
  end

  // History is seeded from the pins so a reset never fakes an edge.
  always_ff @(posedge mclk) begin
    if (clear) begin
      prevReg <= level;
      hitReg  <= 1'b0;
    end else begin
      prevReg <= prevNext;
      hitReg  <= hitNext;
    end
  end

  assign edgeHit = hitReg;

endmodule
`default_nettype wire

// ### logic/asc_aux_control.sv
// Summary of operation
// - Port pins tri-stated while power-on reset.
// - Port latch follows strap after power-on.
// - Strap low: alternate output off until written.
// - Enabled P1.0-1.2 edge sets flag bit 7.
// - Bit 6 high turns brown-out detection off.
// - Bit 5 picks brown-out reset or interrupt.
// - Bit 4 low: detector on always.
// - Bit 4 high: detector on in power-down.
// - Power-down with detection enables RC oscillator.
// - Bit 3 write one resets whole chip.
// - Bit 2 enables the converter circuit.
// - Bit 1 routes square wave to P1.0.
// - P2.1 crystal input, P2.0 crystal/clock out.
`timescale 1ns/100ps
`default_nettype none
module asc_aux_control #(
  parameter int SQUARE_HALF = asc_pkg::SQUARE_HALF,
  parameter int CLOCK_OUTPUT_PIN_HALF = asc_pkg::CLOCK_OUTPUT_PIN_HALF
) (
  input  wire logic        mclk,           // System clock, 100 MHz.
  input  wire logic        rst_n,          // Synchronous reset, active low.
  input  wire logic        wb_cyc_i,       // Wishbone cycle.
  input  wire logic        wb_stb_i,       // Wishbone strobe.
  input  wire logic        wb_we_i,        // Wishbone write enable.
  input  wire logic [9:0]  wb_adr_i,       // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,       // Wishbone write data.
  output logic      [31:0] wb_dat_o,       // Wishbone read data.
  output logic             wb_ack_o,       // Wishbone acknowledge.
  input  wire logic        porIn,          // Power-on detector, high in reset.
  input  wire logic        brownoutIn,     // Brown-out comparator, high on low supply.
  input  wire logic        powerDown,      // Core is in power-down mode.
  input  wire logic        portHighStrap,  // Reset-port-high option bit.
  input  wire logic        clockOutStrap,  // Option bit: P2.0 is clock output.
  input  wire logic        crystalDrive,   // Oscillator drive for crystal output.
  input  wire logic [7:0]  p1AltOut,       // Alternate-function outputs of port 1.
  input  wire logic [7:0]  p1AltEn,        // Alternate-function selects of port 1.
  input  wire logic [7:0]  p1In,           // Port 1 pin levels.
  output logic      [7:0]  p1Out,          // Port 1 pin drive values.
  output logic      [7:0]  p1OeN,          // Port 1 enables, low drives.
  input  wire logic [1:0]  p2In,           // Port 2 pin levels.
  output logic      [1:0]  p2Out,          // Port 2 pin drive values.
  output logic      [1:0]  p2OeN,          // Port 2 enables, low drives.
  output logic             crystalIn,      // Crystal input to the oscillator.
  output logic             chipResetOut,   // Chip-wide reset, active high.
  output logic             brownoutIrq,    // Brown-out interrupt request.
  output logic             brownoutFlag,   // Brown-out seen while detecting.
  output logic             edgeIrq,        // Edge-detect interrupt request.
  output logic             converterOn,    // Converter circuit enable.
  output logic             detectorPower,  // Brown-out detector power.
  output logic             rcOscEnable     // Internal RC oscillator enable.
);

  // ----------------------------------------------------------------
  // Synchronisers and edge detection.
  // ----------------------------------------------------------------
  localparam int SYNC_W = asc_pkg::EDGE_PINS + 2;

  logic [SYNC_W-1:0] syncLevels;
  logic              porSync, brownSync;
  logic [2:0]        edgeLevel;
  logic              edgeHit;
  logic              regReset;
  asc_pkg::asc_aux_t  auxReg,  auxNext;
  asc_pkg::asc_edge_t edgeReg, edgeNext;

  asc_sync3 #(.WIDTH(SYNC_W)) u_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .asyncIn ({p1In[2:0], brownoutIn, !porIn}),
    .syncOut (syncLevels)
  );

  assign porSync   = !syncLevels[0];  // Carried as power-good, so the cleared stage means in reset.
  assign brownSync = syncLevels[1];
  assign edgeLevel = syncLevels[4:2];

  asc_edge_det #(.PINS(asc_pkg::EDGE_PINS)) u_edge (
    .mclk    (mclk),
    .clear   (regReset),
    .level   (edgeLevel),
    .enable  ({edgeReg.edge2Enable, edgeReg.edge1Enable, edgeReg.edge0Enable}),
    .rising  ({edgeReg.edge2Polarity, edgeReg.edge1Polarity, edgeReg.edge0Polarity}),
    .edgeHit (edgeHit)
  );

  // ----------------------------------------------------------------
  // Reset sequencer.
  // ----------------------------------------------------------------
  asc_pkg::asc_rst_state_t stateReg, stateNext;
  logic [7:0] holdReg, holdNext;
  logic       chipRstReg, chipRstNext;
  logic       boActive, boResetReq;

  // Detection works only while enabled and the detector is powered.
  assign boActive   = detectorPower && brownSync;
  // Brown-out resets the chip unless routed to the interrupt.
  assign boResetReq = boActive && !auxReg.brownoutIrqSelect;
  assign regReset   = !rst_n || chipRstReg;

  // A software reset holds the chip in reset for a fixed pulse.
  always_comb begin
    stateNext = stateReg;
    holdNext  = holdReg;
    unique case (stateReg)
      asc_pkg::RS_POR: begin
        if (!porSync) begin
          stateNext = asc_pkg::RS_RUN;
        end
      end
      asc_pkg::RS_RUN: begin
        if (auxReg.softwareReset) begin
          stateNext = asc_pkg::RS_SOFT;
          holdNext  = 8'(asc_pkg::SWRST_CYCLES - 1);
        end
      end
      asc_pkg::RS_SOFT: begin
        if (holdReg == 8'h00) begin
          stateNext = asc_pkg::RS_RUN;
        end else begin
          holdNext = holdReg - 8'h01;
        end
      end
      default: begin
        stateNext = asc_pkg::RS_POR;
      end
    endcase
    if (porSync) begin
      stateNext = asc_pkg::RS_POR;
    end
    chipRstNext = (stateNext != asc_pkg::RS_RUN) || boResetReq;
  end

  // The sequencer itself is cleared only by the external reset.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stateReg   <= asc_pkg::RS_POR;
      holdReg    <= 8'h00;
      chipRstReg <= 1'b1;
    end else begin
      stateReg   <= stateNext;
      holdReg    <= holdNext;
      chipRstReg <= chipRstNext;
    end
  end

  assign chipResetOut = chipRstReg;

  // ----------------------------------------------------------------
  // Wishbone slave and registers.
  // ----------------------------------------------------------------
  logic [7:0]  wordIdx;
  logic        access, wrAux, wrEdge, wrLatch;
  logic [7:0]  wrByte;
  logic        ackReg,   ackNext;
  logic [31:0] rdReg,    rdNext;
  logic [7:0]  latchReg, latchNext;

  assign wordIdx = wb_adr_i[9:2];
  assign access  = wb_cyc_i && wb_stb_i && !ackReg;
  assign wrByte  = wb_dat_i[7:0];
  assign wrAux   = access && wb_we_i && wb_sel_i[0] && (wordIdx == asc_pkg::AUX_IDX);
  assign wrEdge  = access && wb_we_i && wb_sel_i[0] && (wordIdx == asc_pkg::EDGE_IDX);
  assign wrLatch = access && wb_we_i && wb_sel_i[0] && (wordIdx == asc_pkg::LATCH_IDX);

  // Read mux; an unmapped word answers with zero and is still acknowledged.
  always_comb begin
    ackNext = access;
    rdNext  = '0;
    if (access && !wb_we_i) begin
      unique case (wordIdx)
        asc_pkg::AUX_IDX:   rdNext[7:0] = auxReg;
        asc_pkg::EDGE_IDX:  rdNext[7:0] = edgeReg;
        asc_pkg::LATCH_IDX: rdNext[7:0] = latchReg;
        default:            rdNext[7:0] = asc_pkg::READ_ZERO;
      endcase
    end
  end

  // Register updates; hardware setting of the flag wins over a clear.
  always_comb begin
    auxNext  = auxReg;
    edgeNext = edgeReg;
    latchNext = latchReg;
    auxNext.softwareReset = 1'b0;
    if (wrAux) begin
      auxNext = asc_pkg::asc_aux_t'(wrByte);
      auxNext.edgeDetectFlag = auxReg.edgeDetectFlag && wrByte[7];
      auxNext.reserved = 1'b0;
    end
    if (edgeHit) begin
      auxNext.edgeDetectFlag = 1'b1;
    end
    if (wrEdge) begin
      edgeNext = asc_pkg::asc_edge_t'(wrByte);
    end
    if (wrLatch) begin
      latchNext = wrByte;
    end
  end

  // Chip reset clears every control bit, software reset included.
  always_ff @(posedge mclk) begin
    if (regReset) begin
      auxReg  <= asc_pkg::asc_aux_t'(asc_pkg::AUX_RESET_VAL);
      edgeReg <= asc_pkg::asc_edge_t'(asc_pkg::EDGE_RESET_VAL);
    end else begin
      auxReg  <= auxNext;
      edgeReg <= edgeNext;
    end
  end

  // The latch takes its value from the strap while reset lasts.
  always_ff @(posedge mclk) begin
    if (regReset) begin
      latchReg <= portHighStrap ? asc_pkg::PORT_ALL_HIGH : asc_pkg::PORT_ALL_LOW;
    end else begin
      latchReg <= latchNext;
    end
  end

  // The bus answers one cycle after the request, even during chip reset.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ackReg <= 1'b0;
      rdReg  <= '0;
    end else begin
      ackReg <= ackNext;
      rdReg  <= rdNext;
    end
  end

  assign wb_ack_o = ackReg;
  assign wb_dat_o = rdReg;

  // ----------------------------------------------------------------
  // Brown-out control and status outputs.
  // ----------------------------------------------------------------
  logic detPwrNext, rcNext, boFlagNext, boIrqNext;
  logic detPwrReg, rcReg, boFlagReg, boIrqReg, convReg, edgeIrqReg;

  // Low-power bit clear keeps the detector on.
  // Low-power bit set powers it only in power-down.
  // Power-down with detection enabled starts the RC oscillator.
  always_comb begin
    detPwrNext = !auxReg.brownoutDisable && (!auxReg.lowPowerBrownout || powerDown);
    rcNext     = !auxReg.brownoutDisable && powerDown;
    boFlagNext = boActive;
    boIrqNext  = boActive && auxReg.brownoutIrqSelect;
  end

  // Converter enable is a registered copy of its bit.
  // The edge flag is presented as a pending request.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      detPwrReg  <= 1'b0;
      rcReg      <= 1'b0;
      boFlagReg  <= 1'b0;
      boIrqReg   <= 1'b0;
      convReg    <= 1'b0;
      edgeIrqReg <= 1'b0;
    end else begin
      detPwrReg  <= detPwrNext;
      rcReg      <= rcNext;
      boFlagReg  <= boFlagNext;
      boIrqReg   <= boIrqNext;
      convReg    <= auxNext.converterEnable;
      edgeIrqReg <= auxNext.edgeDetectFlag;
    end
  end

  assign detectorPower = detPwrReg;
  assign rcOscEnable   = rcReg;
  assign brownoutFlag  = boFlagReg;
  assign brownoutIrq   = boIrqReg;
  assign converterOn   = convReg;
  assign edgeIrq       = edgeIrqReg;

  // ----------------------------------------------------------------
  // Port pins.
  // ----------------------------------------------------------------
  localparam int SQ_W = $clog2(SQUARE_HALF + 1);
  localparam int CO_W = $clog2(CLOCK_OUTPUT_PIN_HALF + 1);

  logic [SQ_W-1:0] sqCntReg, sqCntNext;
  logic [CO_W-1:0] coCntReg, coCntNext;
  logic            sqReg, sqNext, coReg, coNext;
  asc_pkg::asc_pins_t p1Reg, p1Next;
  logic [1:0]      p2Reg, p2Next, p2OeReg, p2OeNext;

  // Square wave and clock output come from free dividers of the core clock.
  always_comb begin
    sqCntNext = sqCntReg + 1'b1;
    sqNext    = sqReg;
    if (sqCntReg == SQ_W'(SQUARE_HALF - 1)) begin
      sqCntNext = '0;
      sqNext    = !sqReg;
    end
    coCntNext = coCntReg + 1'b1;
    coNext    = coReg;
    if (coCntReg == CO_W'(CLOCK_OUTPUT_PIN_HALF - 1)) begin
      coCntNext = '0;
      coNext    = !coReg;
    end
  end

  // Alternate functions pass only where the latch holds a one.
  always_comb begin
    p1Next.value = latchReg & ((p1AltOut & p1AltEn) | ~p1AltEn);
    // A zero latch bit keeps the alternate output off.
    // Square wave reaches P1.0 only when enabled.
    if (auxReg.squareWaveEnable) begin
      p1Next.value[0] = latchReg[0] && sqReg;
    end
    p1Next.oeN = asc_pkg::PORT_ALL_LOW;
    // P2.1 is input only; P2.0 carries crystal drive or clock out.
    p2Next   = {1'b0, clockOutStrap ? coReg : crystalDrive};
    p2OeNext = 2'b10;
    // All pins float while power-on reset lasts.
    if (stateNext == asc_pkg::RS_POR) begin
      p1Next.oeN = asc_pkg::PORT_ALL_HIGH;
      p2OeNext   = asc_pkg::PIN_RELEASED;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sqCntReg <= '0;
      coCntReg <= '0;
      sqReg    <= 1'b0;
      coReg    <= 1'b0;
      p1Reg    <= {asc_pkg::PORT_ALL_LOW, asc_pkg::PORT_ALL_HIGH};
      p2Reg    <= 2'b00;
      p2OeReg  <= asc_pkg::PIN_RELEASED;
    end else begin
      sqCntReg <= sqCntNext;
      coCntReg <= coCntNext;
      sqReg    <= sqNext;
      coReg    <= coNext;
      p1Reg    <= p1Next;
      p2Reg    <= p2Next;
      p2OeReg  <= p2OeNext;
    end
  end

  assign p1Out     = p1Reg.value;
  assign p1OeN     = p1Reg.oeN;
  assign p2Out     = p2Reg;
  assign p2OeN     = p2OeReg;
  // The crystal pin is an analog clock path, so it is not resampled.
  assign crystalIn = p2In[1];

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_por_tristate: assert property (stateReg == asc_pkg::RS_POR |-> p1OeN == asc_pkg::PORT_ALL_HIGH)
    else $error("port 1 driven during power-on reset");
  chk_latch_strap: assert property ($fell(regReset) |-> latchReg == (portHighStrap ? 8'hFF : 8'h00))
    else $error("port latch not set from strap");
  chk_alt_gated: assert property ((!latchReg[1] && stateNext == asc_pkg::RS_RUN) |=> !p1Out[1])
    else $error("alternate output passed a zero latch");
  chk_edge_flag: assert property ((edgeHit && !regReset) |=> auxReg.edgeDetectFlag ##1 edgeIrq)
    else $error("edge did not set flag and request");
  chk_bo_disable: assert property (auxReg.brownoutDisable |=> !detectorPower && !brownoutFlag)
    else $error("detector active while disabled");
  chk_bo_reset: assert property ((boActive && !auxReg.brownoutIrqSelect) |=> chipResetOut)
    else $error("brown-out did not reset chip");
  chk_bo_irq: assert property ((boActive && auxReg.brownoutIrqSelect) |=> brownoutIrq)
    else $error("brown-out interrupt missing");
  chk_lp_off: assert property ((!auxReg.brownoutDisable && !auxReg.lowPowerBrownout) |=> detectorPower)
    else $error("detector off without low-power mode");
  chk_lp_run: assert property ((auxReg.lowPowerBrownout && !powerDown) |=> !detectorPower)
    else $error("low-power detector on in run mode");
  chk_rc_osc: assert property ((powerDown && !auxReg.brownoutDisable) |=> rcOscEnable)
    else $error("RC oscillator not enabled");
  chk_soft_reset: assert property ((wrAux && wrByte[3] && !regReset) |=> ##1 chipResetOut [*2])
    else $error("software reset did not reset chip");
  chk_software_reset_clear: assert property (auxReg.softwareReset |=> !auxReg.softwareReset)
    else $error("software reset bit stuck");
  chk_reserved: assert property ((access && !wb_we_i && wordIdx == asc_pkg::AUX_IDX) |=> !wb_dat_o[0])
    else $error("reserved bit read as one");

endmodule
`default_nettype wire

// ### tb/tb_aux_system_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_aux_system_control;
  // ----------------------------------------------------------------
  // Bench signals; every design input has a value at time zero.
  // ----------------------------------------------------------------
  logic        mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] datI = 32'h0000_0000;
  logic        porIn = 1'b1, brownoutIn = 1'b0, powerDown = 1'b0;
  logic        portHighStrap = 1'b1, clockOutStrap = 1'b0, crystalDrive = 1'b0;
  logic [7:0]  p1AltOut = 8'h05, p1AltEn = 8'h0F, p1In = 8'h00;
  logic [1:0]  p2In = 2'h0;
  logic [31:0] datO;
  logic [7:0]  p1Out, p1OeN;
  logic [1:0]  p2Out, p2OeN;
  logic        ack, crystalIn, chipRst, boIrq, boFlag, edgeIrq, convOn, detPwr, rcOsc;
  logic [2:0]  watch;
  int          failures = 0, checks_done = 0;

  // Short half periods keep the square wave and clock output visible in a brief run.
  asc_aux_control #(.SQUARE_HALF(4), .CLOCK_OUTPUT_PIN_HALF(2)) dut (
    .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .porIn(porIn), .brownoutIn(brownoutIn), .powerDown(powerDown),
    .portHighStrap(portHighStrap), .clockOutStrap(clockOutStrap), .crystalDrive(crystalDrive),
    .p1AltOut(p1AltOut), .p1AltEn(p1AltEn), .p1In(p1In), .p1Out(p1Out), .p1OeN(p1OeN),
    .p2In(p2In), .p2Out(p2Out), .p2OeN(p2OeN), .crystalIn(crystalIn),
    .chipResetOut(chipRst), .brownoutIrq(boIrq), .brownoutFlag(boFlag), .edgeIrq(edgeIrq),
    .converterOn(convOn), .detectorPower(detPwr), .rcOscEnable(rcOsc));

  // The levels that the bounded waits can watch, by index.
  assign watch = {edgeIrq, boIrq, chipRst};

  // The 100 MHz clock.
  always #5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Reporting and waiting.
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // A wait that runs out ends the run at once, since later steps depend on it.
  task automatic waitLvl(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (watch[k] !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
    if (watch[k] !== v) begin
      chk("level wait", {7'h0, v}, {7'h0, watch[k]});
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------
  // Classic single Wishbone cycle; request held until ack is sampled.
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    datI <= {24'h000000, d};
    while (ack !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    q = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      chk("bus ack", 8'h01, 8'h00);
      end_sim();
    end
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, idx, d, q);
  endtask

  task automatic rdChk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    xfer(1'b0, idx, 8'h00, q);
    chk(name, exp, q);
  endtask

  // Power controls: converter, detector power and RC oscillator as three bits.
  task automatic pw(input logic [7:0] a, input logic pd, input logic [2:0] e);
    wr(asc_pkg::AUX_IDX, a);
    powerDown <= pd;
    tick(3);
    chk("power", {5'h00, e}, {5'h00, convOn, detPwr, rcOsc});
  endtask

  // Bit 0 of port 1 (k = 0) or port 2 (k = 1) over 20 cycles: which levels were seen.
  task automatic sq(input string name, input logic k, input logic [7:0] e);
    logic s1, s0, b;
    s1 = 1'b0;
    s0 = 1'b0;
    repeat (20) begin
      @(posedge mclk);
      b = k ? p2Out[0] : p1Out[0];
      s1 |= b === 1'b1;
      s0 |= b === 1'b0;
    end
    chk(name, e, {6'h00, s1, s0});
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    tick(11);
    chk("p1OeN in reset", 8'hFF, p1OeN);
    tick(1);
    rst_n <= 1'b1;
    tick(10);
    chk("p1OeN power-on", 8'hFF, p1OeN);
    porIn <= 1'b0;
    waitLvl(0, 1'b0, 40);
    tick(2);
    chk("p1Out strap high", 8'hF5, p1Out);
    chk("p1OeN running", 8'h00, p1OeN);
    p2In <= 2'h2;
    crystalDrive <= 1'b1;
    tick(3);
    chk("port 2", 8'h19, {3'h0, crystalIn, p2OeN, p2Out});
    // The clock-output option turns P2.0 into a running divider output.
    clockOutStrap <= 1'b1;
    sq("clock out pin", 1'b1, 8'h03);
    rdChk("unmapped", 8'h55, 8'h00);
    // Bit 3 stays clear here so the read-back is not lost to a software reset.
    wr(asc_pkg::AUX_IDX, 8'h75);
    rdChk("aux reserved", asc_pkg::AUX_IDX, 8'h74);
    pw(8'h40, 1'b0, 3'b000);
    pw(8'h04, 1'b0, 3'b110);
    pw(8'h04, 1'b1, 3'b111);
    pw(8'h10, 1'b1, 3'b011);
    pw(8'h10, 1'b0, 3'b000);
    wr(asc_pkg::AUX_IDX, 8'h02);
    sq("square pin", 1'b0, 8'h03);
    wr(asc_pkg::AUX_IDX, 8'h00);
    sq("square pin", 1'b0, 8'h02);
    // Edges: pin 0 rising, then pin 2 falling while pin 1 is not enabled.
    wr(asc_pkg::EDGE_IDX, 8'h03);
    rdChk("edge control", asc_pkg::EDGE_IDX, 8'h03);
    p1In <= 8'h01;
    waitLvl(2, 1'b1, 20);
    wr(asc_pkg::AUX_IDX, 8'h80);
    rdChk("edge flag kept", asc_pkg::AUX_IDX, 8'h80);
    wr(asc_pkg::AUX_IDX, 8'h00);
    waitLvl(2, 1'b0, 10);
    wr(asc_pkg::EDGE_IDX, 8'h10);
    p1In <= 8'h07;
    tick(12);
    chk("edge wrong way", 8'h00, {7'h00, edgeIrq});
    p1In <= 8'h03;
    waitLvl(2, 1'b1, 20);
    wr(asc_pkg::AUX_IDX, 8'h00);
    // Brown-out as interrupt, then as reset.
    wr(asc_pkg::AUX_IDX, 8'h20);
    brownoutIn <= 1'b1;
    waitLvl(1, 1'b1, 20);
    chk("brown-out as irq", 8'h01, {6'h00, chipRst, boFlag});
    brownoutIn <= 1'b0;
    tick(6);
    wr(asc_pkg::AUX_IDX, 8'h00);
    brownoutIn <= 1'b1;
    waitLvl(0, 1'b1, 20);
    brownoutIn <= 1'b0;
    waitLvl(0, 1'b0, 40);
    // Software reset with the strap low.
    portHighStrap <= 1'b0;
    wr(asc_pkg::AUX_IDX, 8'h08);
    waitLvl(0, 1'b1, 10);
    waitLvl(0, 1'b0, 40);
    rdChk("aux after reset", asc_pkg::AUX_IDX, 8'h00);
    chk("p1Out strap low", 8'h00, p1Out);
    wr(asc_pkg::LATCH_IDX, 8'h0F);
    tick(2);
    chk("p1Out latch set", 8'h05, p1Out);
    end_sim();
  end
endmodule
`default_nettype wire
